// >>> hdl/lpa_consts.svh
// Offsets, field positions and reset values of the partner ability block.
// Included by the package and the bench; definitions only.
`ifndef LPA_CONSTS_SVH
`define LPA_CONSTS_SVH

// Register addresses (5-bit management space)
`define LPA_ADDR_ABILITY 5'h05
`define LPA_ADDR_CTRL 5'h10
`define LPA_ADDR_STATUS 5'h11

// Base-page field positions
`define LPA_BIT_NEXT_PAGE 15
`define LPA_BIT_ACK 14
`define LPA_BIT_REMOTE_FAULT 13
`define LPA_BIT_RESERVED 12
`define LPA_BIT_ASYM_PAUSE 11
`define LPA_BIT_PAUSE 10
`define LPA_BIT_FAST_FOUR_PAIR 9
`define LPA_BIT_FAST_FULL_DUPLEX 8
`define LPA_BIT_FAST_HALF_DUPLEX 7
`define LPA_BIT_SLOW_FULL_DUPLEX 6
`define LPA_BIT_SLOW_HALF_DUPLEX 5
`define LPA_SELECTOR_MSB 4

// Base page keeps every bit except the reserved one
`define LPA_BASE_KEEP 16'hefff
`define LPA_NEXT_KEEP 16'hffff
`define LPA_WORD_RESET 16'h0000

// Control register: bit 0 enables the next-page view
`define LPA_CTRL_NP_EN_BIT 0
`define LPA_CTRL_RESET 1'h1

`endif

// >>> hdl/lpa_pkg.sv
// Types shared by the partner ability block.
// Assumes lpa_consts.svh on the include path.
`include "lpa_consts.svh"

package lpa_pkg;
  typedef logic [15:0] word_t;
  typedef logic [4:0] addr_t;
  typedef logic [7:0] count_t;

  // Which view the ability address presents
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BASE = 3'b010,
    ST_NEXT = 3'b100
  } view_state_e;
endpackage : lpa_pkg

// >>> hdl/lpa_capture.sv
// Holding register for one received page word.
// Assumes load and clear come from logic on the same clock.
`timescale 1ns/1ps

module lpa_capture #(
  parameter logic [15:0] KEEP = 16'hffff
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // Control
  input wire logic i_load,
  input wire logic i_clear,
  // Data
  input wire lpa_pkg::word_t i_data,
  output lpa_pkg::word_t o_q
);
  import lpa_pkg::*;

  // Clear beats load so a restart never keeps a stale page
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_q <= `LPA_WORD_RESET;
    end else if (i_clear) begin
      o_q <= `LPA_WORD_RESET;
    end else if (i_load) begin
      o_q <= i_data & KEEP;
    end
  end
endmodule : lpa_capture

// >>> hdl/lpa_read_port.sv
// Read side of the management port: decode and registered read data.
// Assumes one-cycle read strobes from a master on the same clock.
`timescale 1ns/1ps

module lpa_read_port (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // Request
  input wire lpa_pkg::addr_t i_addr,
  input wire logic i_rd,
  // Register contents
  input wire lpa_pkg::word_t i_ability,
  input wire lpa_pkg::word_t i_ctrl,
  input wire lpa_pkg::word_t i_status,
  // Answer
  output lpa_pkg::word_t o_rdata,
  output logic o_rd_valid
);
  import lpa_pkg::*;

  word_t sel_nxt;

  always_comb begin
    case (i_addr)
      `LPA_ADDR_ABILITY: sel_nxt = i_ability;
      `LPA_ADDR_CTRL: sel_nxt = i_ctrl;
      `LPA_ADDR_STATUS: sel_nxt = i_status;
      default: sel_nxt = `LPA_WORD_RESET;
    endcase
  end

  // Data stand only in the cycle after the strobe
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= `LPA_WORD_RESET;
      o_rd_valid <= 1'b0;
    end else begin
      o_rdata <= i_rd ? sel_nxt : `LPA_WORD_RESET;
      o_rd_valid <= i_rd;
    end
  end
endmodule : lpa_read_port

// >>> hdl/link_partner_ability_capture.sv
// Link partner ability register with base-page and next-page views.
// Assumes page words and negotiation status come from the negotiation
// logic on i_ref_clk, and a simple one-cycle register port.
//
// How it works
// - Address 0x05 returns the ability word received from the partner.
// - With next pages on, a next page after negotiation replaces the view.
// - Base bit 15 shows the partner's next page request; resets 0.
// - Base bit 14 shows partner acknowledge, set only by negotiation.
// - Base bit 13 shows partner remote fault; resets 0.
// - Base bit 12 is reserved and always reads 0.
// - Base bit 11 shows partner asymmetric pause; resets 0.
// - Base bit 10 shows partner symmetric pause; resets 0.
// - Base bit 9 shows partner four-pair fast capability; resets 0.
// - Base bit 8 shows partner fast full duplex; resets 0.
// - Base bit 7 shows partner fast half duplex; resets 0.
// - Base bit 6 shows partner slow full duplex; resets 0.
// - Base bit 5 shows partner slow half duplex; resets 0.
// - Bits 4:0 hold the partner selector as received; reset zero.
// - Next view bits 15 and 14 show request and acknowledge.
// - Next view bit 13 is message page, bit 12 comply ability.
// - Next view bit 11 is toggle, bits 10:0 page code.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps

module link_partner_ability_capture (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // Register port
  input wire lpa_pkg::addr_t i_addr,
  input wire lpa_pkg::word_t i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output lpa_pkg::word_t o_rdata,
  output logic o_rd_valid,
  // From the negotiation logic
  input wire logic i_page_valid,
  input wire logic i_page_next,
  input wire lpa_pkg::word_t i_page_word,
  input wire logic i_an_complete,
  input wire logic i_an_restart,
  // Current view for other logic
  output lpa_pkg::word_t o_lp_word,
  output logic o_next_view
);
  import lpa_pkg::*;

  view_state_e state_r;
  view_state_e state_nxt;
  word_t base_q;
  word_t next_q;
  word_t link_partner_ability_reg_r;
  word_t ctrl_word;
  word_t status_word;
  logic np_en_r;
  logic base_seen_r;
  count_t page_cnt_r;
  logic base_load;
  logic next_load;
  logic any_load;

  // Pages from the partner
  assign base_load = i_page_valid && !i_page_next && !i_an_restart;
  // Next pages count only once negotiation has succeeded
  assign next_load = i_page_valid && i_page_next && !i_an_restart && np_en_r
    && i_an_complete && (state_r != ST_IDLE);
  assign any_load = base_load || next_load;

  // View selection
  always_comb begin
    case (state_r)
      ST_IDLE: state_nxt = base_load ? ST_BASE : ST_IDLE;
      ST_BASE: state_nxt = next_load ? ST_NEXT : ST_BASE;
      ST_NEXT: state_nxt = base_load ? ST_BASE : ST_NEXT;
      default: state_nxt = ST_IDLE;
    endcase
    if (i_an_restart) begin
      state_nxt = ST_IDLE;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Reserved bit 12 is masked off at capture
  lpa_capture #(
    .KEEP(`LPA_BASE_KEEP)
  ) u_base (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_load(base_load),
    .i_clear(i_an_restart),
    .i_data(i_page_word),
    .o_q(base_q)
  );

  // Next page keeps every field as received
  lpa_capture #(
    .KEEP(`LPA_NEXT_KEEP)
  ) u_next (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_load(next_load),
    .i_clear(i_an_restart),
    .i_data(i_page_word),
    .o_q(next_q)
  );

  // One register stage so the view output comes from a flop
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      link_partner_ability_reg_r <= `LPA_WORD_RESET;
    end else begin
      case (state_r)
        ST_BASE: link_partner_ability_reg_r <= base_q;
        ST_NEXT: link_partner_ability_reg_r <= next_q;
        default: link_partner_ability_reg_r <= `LPA_WORD_RESET;
      endcase
    end
  end

  assign o_lp_word = link_partner_ability_reg_r;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_next_view <= 1'b0;
    end else begin
      o_next_view <= (state_nxt == ST_NEXT);
    end
  end

  // Control: the only writable register; writes to 0x05 fall through
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      np_en_r <= `LPA_CTRL_RESET;
    end else if (i_wr && i_addr == `LPA_ADDR_CTRL) begin
      np_en_r <= i_wdata[`LPA_CTRL_NP_EN_BIT];
    end
  end

  // Status: base page seen and count of next pages, wraps at 255
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      base_seen_r <= 1'b0;
      page_cnt_r <= 8'h00;
    end else if (i_an_restart) begin
      base_seen_r <= 1'b0;
      page_cnt_r <= 8'h00;
    end else begin
      if (base_load) begin
        base_seen_r <= 1'b1;
        page_cnt_r <= 8'h00;
      end else if (next_load) begin
        page_cnt_r <= 8'(page_cnt_r + 8'h01);
      end
    end
  end

  assign ctrl_word = {15'h0000, np_en_r};
  assign status_word = {page_cnt_r, 6'h00, o_next_view, base_seen_r};

  lpa_read_port u_read (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_addr(i_addr),
    .i_rd(i_rd),
    .i_ability(link_partner_ability_reg_r),
    .i_ctrl(ctrl_word),
    .i_status(status_word),
    .o_rdata(o_rdata),
    .o_rd_valid(o_rd_valid)
  );

  // Checks on the block's own behaviour
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_b);

  sequence base_arrives_s;
    base_load;
  endsequence

  sequence next_arrives_s;
    next_load;
  endsequence

  sequence ability_read_s;
    i_rd && i_addr == `LPA_ADDR_ABILITY;
  endsequence

  ability_read_a: assert property (
    ability_read_s |=> o_rd_valid && o_rdata == $past(link_partner_ability_reg_r)
  ) else $error("ability read returned wrong word");

  next_view_a: assert property (
    next_arrives_s |-> ##1 o_next_view ##1 o_lp_word == $past(i_page_word, 2)
  ) else $error("next page did not replace the view");

  next_gate_a: assert property (
    $rose(state_r == ST_NEXT) |-> $past(np_en_r) && $past(i_an_complete)
  ) else $error("next view entered without enable or completion");

  base_word_a: assert property (
    base_arrives_s |-> ##2 o_lp_word[15:13] == $past(i_page_word[15:13], 2)
  ) else $error("base page upper flags wrong");

  ack_source_a: assert property (
    $changed(o_lp_word[`LPA_BIT_ACK]) |-> $past(any_load || i_an_restart, 2)
  ) else $error("acknowledge changed without a received page");

  fault_flag_a: assert property (
    base_arrives_s ##2 (state_r == ST_BASE)
      |-> o_lp_word[`LPA_BIT_REMOTE_FAULT] == $past(i_page_word[13], 2)
  ) else $error("remote fault flag wrong");

  reserved_zero_a: assert property (
    state_r != ST_NEXT && $past(state_r) != ST_NEXT
      |=> !o_lp_word[`LPA_BIT_RESERVED]
  ) else $error("reserved bit read as one");

  pause_bits_a: assert property (
    base_arrives_s |-> ##2 o_lp_word[11:10] == $past(i_page_word[11:10], 2)
  ) else $error("pause capability bits wrong");

  sym_pause_a: assert property (
    base_arrives_s |-> ##2
      o_lp_word[`LPA_BIT_PAUSE] == $past(i_page_word[`LPA_BIT_PAUSE], 2)
  ) else $error("symmetric pause bit wrong");

  four_pair_a: assert property (
    base_arrives_s |-> ##2 o_lp_word[`LPA_BIT_FAST_FOUR_PAIR]
      == $past(i_page_word[`LPA_BIT_FAST_FOUR_PAIR], 2)
  ) else $error("four pair bit wrong");

  fast_duplex_a: assert property (
    base_arrives_s |-> ##2 o_lp_word[`LPA_BIT_FAST_FULL_DUPLEX]
      == $past(i_page_word[`LPA_BIT_FAST_FULL_DUPLEX], 2)
  ) else $error("fast full duplex bit wrong");

  fast_half_a: assert property (
    base_arrives_s |-> ##2 o_lp_word[`LPA_BIT_FAST_HALF_DUPLEX]
      == $past(i_page_word[`LPA_BIT_FAST_HALF_DUPLEX], 2)
  ) else $error("fast half duplex bit wrong");

  slow_caps_a: assert property (
    base_arrives_s |-> ##2 o_lp_word[6:5] == $past(i_page_word[6:5], 2)
  ) else $error("slow capability bits wrong");

  slow_half_a: assert property (
    base_arrives_s |-> ##2 o_lp_word[`LPA_BIT_SLOW_HALF_DUPLEX]
      == $past(i_page_word[`LPA_BIT_SLOW_HALF_DUPLEX], 2)
  ) else $error("slow half duplex bit wrong");

  selector_field_a: assert property (
    base_arrives_s |-> ##2 o_lp_word[`LPA_SELECTOR_MSB:0] == $past(i_page_word[4:0], 2)
  ) else $error("selector field wrong");

  idle_zero_a: assert property (
    state_r == ST_IDLE ##1 state_r == ST_IDLE |-> o_lp_word == `LPA_WORD_RESET
  ) else $error("view not zero while no page held");

  next_flags_a: assert property (
    next_arrives_s |-> ##2 o_lp_word[13:12] == $past(i_page_word[13:12], 2)
  ) else $error("message page or comply flag wrong");

  next_code_a: assert property (
    next_arrives_s |-> ##2 o_lp_word[11:0] == $past(i_page_word[11:0], 2)
  ) else $error("toggle or page code wrong");

  write_ignored_a: assert property (
    i_wr && i_addr == `LPA_ADDR_ABILITY && !any_load && !i_an_restart
      |=> $stable(base_q) && $stable(next_q)
  ) else $error("write changed the ability register");

  read_once_a: assert property (
    !i_rd |=> !o_rd_valid && o_rdata == `LPA_WORD_RESET
  ) else $error("read data stood without a strobe");

  // Negotiation gates, restart and the block's own registers
  sequence restart_s;
    i_an_restart;
  endsequence

  // Next page seen while gated off, with no restart beside it
  sequence next_refused_s;
    i_page_valid && i_page_next && !next_load && !i_an_restart;
  endsequence

  restart_clear_a: assert property (
    restart_s |-> ##1 !o_next_view ##1 o_lp_word == `LPA_WORD_RESET
  ) else $error("restart left a page in the view");

  base_view_back_a: assert property (
    base_arrives_s |=> !o_next_view
  ) else $error("base page did not return to the base view");

  // A refused next page must leave no trace, count included
  next_refused_a: assert property (
    next_refused_s
      |=> $stable(next_q) && $stable(state_r) && $stable(page_cnt_r)
  ) else $error("refused next page changed the block");

  next_upper_a: assert property (
    next_arrives_s |-> ##2 o_lp_word[15:14] == $past(i_page_word[15:14], 2)
  ) else $error("next page request or acknowledge wrong");

  base_seen_a: assert property (
    base_arrives_s |=> base_seen_r && page_cnt_r == 8'h00
  ) else $error("base page not recorded in status");

  // Counter wraps on purpose; software only needs the low bits
  page_count_a: assert property (
    next_arrives_s |=> page_cnt_r == 8'($past(page_cnt_r) + 8'h01)
  ) else $error("next page count did not step");

  restart_status_a: assert property (
    restart_s |=> !base_seen_r && page_cnt_r == 8'h00
  ) else $error("restart did not clear the status");

  ctrl_write_a: assert property (
    i_wr && i_addr == `LPA_ADDR_CTRL
      |=> np_en_r == $past(i_wdata[`LPA_CTRL_NP_EN_BIT])
  ) else $error("control write not taken");

  ctrl_read_a: assert property (
    i_rd && i_addr == `LPA_ADDR_CTRL |=> o_rd_valid && o_rdata[15:1] == 15'h0000
      && o_rdata[`LPA_CTRL_NP_EN_BIT] == $past(np_en_r)
  ) else $error("control read wrong");

  status_read_a: assert property (
    i_rd && i_addr == `LPA_ADDR_STATUS
      |=> o_rd_valid && o_rdata[7:2] == 6'h00 && o_rdata[0] == $past(base_seen_r)
  ) else $error("status read wrong");

  unmapped_read_a: assert property (
    i_rd && i_addr != `LPA_ADDR_ABILITY && i_addr != `LPA_ADDR_CTRL
      && i_addr != `LPA_ADDR_STATUS |=> o_rd_valid && o_rdata == `LPA_WORD_RESET
  ) else $error("unmapped read not zero");
endmodule : link_partner_ability_capture

// >>> bench/page_source.sv
// Behavioural negotiation source feeding received page words to the block.
// Assumes the block's clock; every page and restart is a one-cycle pulse.
`timescale 1ns/1ps

module page_source (
  // Clock
  input wire logic i_ref_clk,
  // Towards the block
  output logic o_page_valid,
  output logic o_page_next,
  output lpa_pkg::word_t o_page_word,
  output logic o_an_complete,
  output logic o_an_restart
);
  import lpa_pkg::*;

  initial begin
    o_page_valid = 1'b0;
    o_page_next = 1'b0;
    o_page_word = 16'h0000;
    o_an_complete = 1'b0;
    o_an_restart = 1'b0;
  end

  task automatic send(input word_t w, input logic nxt);
    @(posedge i_ref_clk);
    o_page_valid <= 1'b1;
    o_page_next <= nxt;
    o_page_word <= w;
    @(posedge i_ref_clk);
    o_page_valid <= 1'b0;
    // Stale word is not held, so a late capture shows up
    o_page_word <= ~w;
    o_page_next <= ~nxt;
  endtask : send

  task automatic set_done(input logic d);
    @(posedge i_ref_clk);
    o_an_complete <= d;
  endtask : set_done

  task automatic restart;
    @(posedge i_ref_clk);
    o_an_restart <= 1'b1;
    @(posedge i_ref_clk);
    o_an_restart <= 1'b0;
  endtask : restart
endmodule : page_source

// >>> bench/tb.sv
// Self-checking bench for the partner ability register.
// Assumes the design files and lpa_consts.svh are compiled first.
`timescale 1ns/1ps
`include "lpa_consts.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end

module tb;
  import lpa_pkg::*;
  logic i_ref_clk, i_rst_b, i_wr, i_rd, pv, pn, ac, ar, o_rd_valid, o_next_view;
  addr_t i_addr;
  word_t i_wdata, pw, o_rdata, o_lp_word, w, held;
  logic [31:0] rnd;
  int failures, comparisons;

  page_source ps_u (.i_ref_clk(i_ref_clk), .o_page_valid(pv), .o_page_next(pn),
    .o_page_word(pw), .o_an_complete(ac), .o_an_restart(ar));
  link_partner_ability_capture dut_u (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_rd_valid(o_rd_valid), .i_page_valid(pv), .i_page_next(pn), .i_page_word(pw),
    .i_an_complete(ac), .i_an_restart(ar), .o_lp_word(o_lp_word),
    .o_next_view(o_next_view));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Reserved bit never shows in the base view
  function automatic word_t base_exp(input word_t v);
    return v & 16'hefff;
  endfunction : base_exp

  task automatic wr(input addr_t a, input word_t d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rchk(input addr_t a, input word_t e, input string n);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1;
    `CHK("read strobe answer", 1'b1, o_rd_valid)
    `CHK(n, e, o_rdata)
  endtask : rchk

  task automatic tally_and_finish;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  initial begin
    #300000;
    failures++;
    tally_and_finish;
  end

  initial begin
    i_rst_b = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 5'h00;
    i_wdata = 16'h0000;
    rnd = 32'h2d00;
    repeat (6) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    rchk(`LPA_ADDR_ABILITY, 16'h0000, "word after reset");
    `CHK("view after reset", 1'b0, o_next_view)
    rchk(`LPA_ADDR_CTRL, 16'(`LPA_CTRL_RESET), "ctrl after reset");
    // One-hot walk over every base bit, then random words
    for (int k = 0; k < 40; k++) begin
      w = (k < 16) ? 16'h0001 << k : rnd[15:0];
      rnd = lfsr(rnd);
      ps_u.send(w, 1'b0);
      rchk(`LPA_ADDR_ABILITY, base_exp(w), "base view");
      `CHK("current word", base_exp(w), o_lp_word)
      wr(`LPA_ADDR_ABILITY, rnd[31:16]);
      rchk(`LPA_ADDR_ABILITY, base_exp(w), "base after write");
    end
    held = w;
    ps_u.send(rnd[15:0], 1'b1);
    rchk(`LPA_ADDR_ABILITY, base_exp(held), "next before done");
    ps_u.set_done(1'b1);
    for (int k = 0; k < 12; k++) begin
      w = (k == 0) ? 16'h1000 : (k == 1) ? 16'hffff : rnd[15:0];
      rnd = lfsr(rnd);
      ps_u.send(w, 1'b1);
      rchk(`LPA_ADDR_ABILITY, w, "next view");
      `CHK("next view flag", 1'b1, o_next_view)
      wr(`LPA_ADDR_ABILITY, ~w);
      rchk(`LPA_ADDR_ABILITY, w, "next after write");
    end
    rchk(`LPA_ADDR_STATUS, {8'h0c, 6'h00, 2'h3}, "status in next view");
    held = w;
    // View disabled: further next pages are dropped
    wr(`LPA_ADDR_CTRL, 16'h0000);
    rchk(`LPA_ADDR_CTRL, 16'h0000, "ctrl disabled");
    ps_u.send(~held, 1'b1);
    rchk(`LPA_ADDR_ABILITY, held, "next while disabled");
    rchk(`LPA_ADDR_STATUS, {8'h0c, 6'h00, 2'h3}, "status while disabled");
    wr(`LPA_ADDR_CTRL, 16'h0001);
    w = rnd[15:0] | 16'h1000;
    ps_u.send(w, 1'b0);
    rchk(`LPA_ADDR_ABILITY, base_exp(w), "back to base");
    `CHK("base view flag", 1'b0, o_next_view)
    rchk(`LPA_ADDR_STATUS, {8'h00, 6'h00, 2'h1}, "status back to base");
    ps_u.restart;
    rchk(`LPA_ADDR_ABILITY, 16'h0000, "after restart");
    rchk(`LPA_ADDR_STATUS, 16'h0000, "status after restart");
    rchk(5'h1f, 16'h0000, "unmapped read");
    // Mid-run reset drops the held page and restores the enable
    wr(`LPA_ADDR_CTRL, 16'h0000);
    ps_u.send(rnd[15:0], 1'b0);
    @(posedge i_ref_clk);
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    #1;
    `CHK("word in reset", 16'h0000, o_lp_word)
    `CHK("view in reset", 1'b0, o_next_view)
    `CHK("read valid in reset", 1'b0, o_rd_valid)
    @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    rchk(`LPA_ADDR_CTRL, 16'(`LPA_CTRL_RESET), "ctrl after mid reset");
    rchk(`LPA_ADDR_ABILITY, 16'h0000, "word after mid reset");
    tally_and_finish;
  end
endmodule : tb
